/* File: charge_status_encoder.sv */
// charger status encoder: charge state machine and open-drain status carrier
// Behaviour
// RQ1 - status encodes four charger conditions
// RQ2 - charging holds status pin low
// RQ3 - charge complete releases status pin
// RQ4 - end-of-charge ignored during input current limit
// RQ5 - faults shown as carrier with alternating duty
// RQ6 - temperature fault: 6.25/93.75 %, 1.5 Hz
// RQ7 - bad battery: 12.5/87.5 %, 6.1 Hz
// RQ8 - below trickle for half hour: bad battery
// RQ9 - host discards exact 50 % readings
// RQ10 - host may unload then reset charger
// RQ11 - hot or cold comparator pauses charging
// RQ12 - float mode freezes safety timer on fault
// RQ13 - grounded thermistor disables temperature functions
// RQ14 - disable input high stops the charger
// RQ15 - host holds disable high for suspend
// RQ16 - regulator on: above lockout, no suspend
// RQ17 - ideal diode always enabled
// RQ18 - brief disable restarts cycle and timers
// RQ19 - carrier and blinks divided from one clock
`timescale 1ns/10ps
`default_nettype none
module charge_status_encoder
   import charge_status_pkg::*;
#(
   parameter int HALF_TEMP = HALF_TEMP_CYC,
   parameter int HALF_BAD  = HALF_BAD_CYC,
   parameter int MS_LEN    = MS_CYC,
   parameter int TRKL_LEN  = TRKL_MS,
   parameter int SAFE_LEN  = SAFETY_MS
) (
   input  wire logic   clk_sys,
   input  wire logic   nrst,
   input  wire sense_t sense,
   output logic        charge_status_out,
   output logic        charge_status_oe,
   output logic        charger_run,
   output logic        regulator_en,
   output logic        ideal_diode_en
);

   // =====================================================
   // helpers

   // steps pulled low in one carrier period
   function automatic logic [4:0] lo_steps(input ind_t ind, input logic ph);
      logic [4:0] base;
      base = (ind == IND_TEMP) ? TEMP_LO_STEPS : BAD_LO_STEPS;
      case (ind)
         IND_LOW: lo_steps = FULL_STEPS;
         IND_REL: lo_steps = 5'h00;
         default: lo_steps = ph ? 5'(FULL_STEPS - base) : base;
      endcase
   endfunction : lo_steps

   // half blink period for the active fault
   function automatic logic [31:0] half_len(input ind_t ind);
      half_len = (ind == IND_TEMP) ? 32'(HALF_TEMP) : 32'(HALF_BAD);
   endfunction : half_len

   // =====================================================
   // state

   core_t st_r;
   core_t st_nxt;
   sense_t s;
   logic   temp_bad;
   logic   enabled;
   ind_t   ind_now;

   assign s        = st_r.s2;
   // grounded thermistor masks both comparators
   assign temp_bad = (s.temp_hot | s.temp_cold) & ~s.thermistor_gnd; // RQ11 RQ13
   assign enabled  = ~s.charger_disable_input & s.uvlo_ok; // RQ14

   // indication from charge state, four classes only
   always_comb begin
      case (st_r.state) // RQ1
         S_BAD:   ind_now = IND_BAD;
         S_CHG: begin
            if (temp_bad) begin
               ind_now = IND_TEMP;
            end else if (st_r.eoc_seen) begin
               ind_now = IND_REL;
            end else begin
               ind_now = IND_LOW;
            end
         end
         default: ind_now = IND_REL;
      endcase
   end

   // =====================================================
   // next state
   always_comb begin
      st_nxt    = st_r;
      // two-stage synchroniser for analog comparator levels
      st_nxt.s1 = sense;
      st_nxt.s2 = st_r.s1;

      // millisecond enable for the long timers
      st_nxt.ms_tick = 1'b0;
      if (st_r.ms_cnt >= 32'(MS_LEN - 1)) begin // RQ19
         st_nxt.ms_cnt  = 32'h0;
         st_nxt.ms_tick = 1'b1;
      end else begin
         st_nxt.ms_cnt = st_r.ms_cnt + 32'h1;
      end

      // charge state machine
      case (st_r.state)
         S_CHG: begin
            // false completion is masked in current limit
            if (s.eoc && !s.in_limit) begin // RQ4
               st_nxt.eoc_seen = 1'b1; // RQ3
            end
            // bad cell timer, restarts on any recovery
            if (!s.bat_low) begin
               st_nxt.trkl_ms = 32'h0;
            end else if (st_r.ms_tick) begin
               st_nxt.trkl_ms = st_r.trkl_ms + 32'h1;
            end
            if (s.bat_low && st_r.ms_tick && st_r.trkl_ms >= 32'(TRKL_LEN - 1)) begin
               st_nxt.state = S_BAD; // RQ8
            end
            // safety timer runs in float mode, frozen on temperature fault
            if (s.float_cv && !temp_bad && st_r.ms_tick) begin // RQ12
               st_nxt.safety_ms = st_r.safety_ms + 32'h1;
               if (st_r.safety_ms >= 32'(SAFE_LEN - 1)) begin
                  st_nxt.state    = S_DONE;
                  st_nxt.eoc_seen = 1'b1;
               end
            end
         end
         S_DONE: begin
            // recharge starts a fresh cycle
            if (s.recharge) begin
               st_nxt.state     = S_CHG;
               st_nxt.eoc_seen  = 1'b0;
               st_nxt.safety_ms = 32'h0;
               st_nxt.trkl_ms   = 32'h0;
            end
         end
         S_BAD: begin
            // held until the host disables the charger or the input drops below lockout
            st_nxt.state = S_BAD; // RQ10
         end
         S_OFF: begin
            st_nxt.state = S_CHG;
         end
         default: begin
            st_nxt.state = S_OFF;
         end
      endcase

      // disable or lockout clears the whole cycle
      if (!enabled) begin // RQ14 RQ18
         st_nxt.state     = S_OFF;
         st_nxt.eoc_seen  = 1'b0;
         st_nxt.safety_ms = 32'h0;
         st_nxt.trkl_ms   = 32'h0;
      end

      // carrier: DUTY_STEPS steps of STEP_CYC clocks
      if (st_r.step_cnt >= 32'(STEP_CYC - 1)) begin // RQ5 RQ19
         st_nxt.step_cnt = 32'h0;
         st_nxt.step_idx = st_r.step_idx + 4'h1;
      end else begin
         st_nxt.step_cnt = st_r.step_cnt + 32'h1;
      end

      // blink phase; restarts whenever the indication changes
      st_nxt.ind = ind_now;
      if (ind_now != st_r.ind) begin
         st_nxt.blink_cnt = 32'h0;
         st_nxt.blink_ph  = 1'b0;
      end else if (st_r.blink_cnt >= half_len(st_r.ind) - 32'h1) begin // RQ6 RQ7
         st_nxt.blink_cnt = 32'h0;
         st_nxt.blink_ph  = ~st_r.blink_ph;
      end else begin
         st_nxt.blink_cnt = st_r.blink_cnt + 32'h1;
      end

      // open-drain pin: enable high means pulled low
      st_nxt.stat_oe  = {1'b0, st_r.step_idx} < lo_steps(st_r.ind, st_r.blink_ph); // RQ2 RQ5
      st_nxt.run      = (st_r.state == S_CHG) && !temp_bad; // RQ11
      st_nxt.reg_en   = s.uvlo_ok && !s.susp_lo && !s.susp_hi; // RQ16
      st_nxt.diode_en = 1'b1; // RQ17
   end

   // =====================================================
   // registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_r          <= '0;
         st_r.state    <= S_OFF;
         st_r.ind      <= IND_REL;
         st_r.diode_en <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign charge_status_out = 1'b0;   // open drain only ever pulls low
   assign charge_status_oe  = st_r.stat_oe;
   assign charger_run       = st_r.run;
   assign regulator_en      = st_r.reg_en;
   assign ideal_diode_en    = st_r.diode_en;

   // =====================================================
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_charge_low: assert property ( // RQ2
      st_r.ind == IND_LOW |=> charge_status_oe)
      else $error("status not low while charging");

   a_done_release: assert property ( // RQ3
      st_r.ind == IND_REL |=> !charge_status_oe)
      else $error("status not released");

   // only a safety timeout may complete the cycle while the input is limited
   a_limit_mask: assert property ( // RQ4
      st_r.state == S_CHG && !st_r.eoc_seen && s.in_limit && s.eoc
      |=> !st_r.eoc_seen || st_r.state == S_DONE)
      else $error("end of charge taken in current limit");

   a_temp_duty: assert property ( // RQ6
      st_r.ind == IND_TEMP && st_r.blink_ph
      |=> charge_status_oe == ($past(st_r.step_idx) < 4'hF))
      else $error("temperature fault duty wrong");

   a_bad_duty: assert property ( // RQ7
      st_r.ind == IND_BAD && !st_r.blink_ph
      |=> charge_status_oe == ($past(st_r.step_idx) < 4'h2))
      else $error("bad battery duty wrong");

   a_carrier_step: assert property ( // RQ5
      st_r.step_cnt == 32'h0 |=> st_r.step_idx == $past(st_r.step_idx))
      else $error("carrier step advanced early");

   a_trkl_fault: assert property ( // RQ8
      st_r.state == S_CHG && enabled && s.bat_low && st_r.ms_tick
      && st_r.trkl_ms >= 32'(TRKL_LEN - 1) |=> st_r.state == S_BAD)
      else $error("bad battery not flagged");

   a_temp_pause: assert property ( // RQ11
      temp_bad |=> !charger_run)
      else $error("charging not paused on temperature");

   a_timer_freeze: assert property ( // RQ12
      st_r.state == S_CHG && enabled && temp_bad |=> $stable(st_r.safety_ms))
      else $error("safety timer ran during fault");

   a_gnd_mask: assert property ( // RQ13
      s.thermistor_gnd |-> !temp_bad && ind_now != IND_TEMP)
      else $error("temperature fault with grounded thermistor");

   a_disable_off: assert property ( // RQ14
      s.charger_disable_input |=> st_r.state == S_OFF ##1 !charger_run)
      else $error("charger not disabled");

   a_disable_restart: assert property ( // RQ18
      !enabled |=> st_r.safety_ms == 32'h0 && st_r.trkl_ms == 32'h0)
      else $error("timers not cleared by disable");

   a_reg_enable: assert property ( // RQ16
      regulator_en == ($past(s.uvlo_ok) && !$past(s.susp_lo) && !$past(s.susp_hi)))
      else $error("regulator enable wrong");

   a_diode_on: assert property ( // RQ17
      ideal_diode_en)
      else $error("ideal diode disabled");

   c_temp_blink: cover property (st_r.ind == IND_TEMP && $changed(st_r.blink_ph));
   c_bad_state: cover property (st_r.state == S_BAD);
   c_done_state: cover property ($rose(st_r.state == S_DONE));
   c_restart: cover property (st_r.state == S_OFF ##1 st_r.state == S_CHG);

endmodule : charge_status_encoder
`default_nettype wire

/* File: charge_status_pkg.sv */
// package: constants and types of the charger status encoder
`default_nettype none
package charge_status_pkg;
   // =====================================================
   // clock and timing
   localparam longint CLK_HZ        = 125_000_000;
   localparam longint CARRIER_HZ    = 35_000;
   localparam int     DUTY_STEPS    = 16;
   localparam int     STEP_CYC      = int'(CLK_HZ / (CARRIER_HZ * DUTY_STEPS));
   localparam longint BLINK_TEMP_MHZ = 1_500;  // blink rate in mHz
   localparam longint BLINK_BAD_MHZ  = 6_100;
   localparam int     HALF_TEMP_CYC = int'(CLK_HZ * 1000 / (2 * BLINK_TEMP_MHZ));
   localparam int     HALF_BAD_CYC  = int'(CLK_HZ * 1000 / (2 * BLINK_BAD_MHZ));
   localparam int     MS_CYC        = int'(CLK_HZ / 1000);
   localparam int     TRKL_MS       = 1_800_000;   // half an hour
   localparam int     SAFETY_MS     = 14_400_000;  // four hours
   // =====================================================
   // duty steps pulled low, out of DUTY_STEPS
   localparam logic [4:0] TEMP_LO_STEPS = 5'h01;  // 6.25 %
   localparam logic [4:0] BAD_LO_STEPS  = 5'h02;  // 12.5 %
   localparam logic [4:0] FULL_STEPS    = 5'h10;
   // =====================================================
   // types
   typedef struct packed {
      logic bat_low;         // battery below trickle threshold
      logic float_cv;        // charger in constant-voltage mode
      logic eoc;             // charge current below end-of-charge level
      logic in_limit;        // input in current limit
      logic temp_hot;        // hot comparator tripped
      logic temp_cold;       // cold comparator tripped
      logic thermistor_gnd;  // thermistor_input tied to ground
      logic charger_disable_input;
      logic uvlo_ok;         // input above undervoltage lockout
      logic susp_lo;         // low-power suspend selected
      logic susp_hi;         // high-power suspend selected
      logic recharge;        // battery below recharge level
   } sense_t;

   typedef enum logic [3:0] {
      S_OFF  = 4'h1,
      S_CHG  = 4'h2,
      S_DONE = 4'h4,
      S_BAD  = 4'h8
   } chg_state_t;

   typedef enum logic [3:0] {
      IND_LOW  = 4'h1,
      IND_REL  = 4'h2,
      IND_TEMP = 4'h4,
      IND_BAD  = 4'h8
   } ind_t;

   typedef struct packed {
      sense_t      s1;       // first synchroniser stage
      sense_t      s2;       // second synchroniser stage
      chg_state_t  state;
      logic        eoc_seen;
      logic [31:0] ms_cnt;
      logic        ms_tick;
      logic [31:0] trkl_ms;
      logic [31:0] safety_ms;
      logic [31:0] step_cnt;
      logic [3:0]  step_idx;
      logic [31:0] blink_cnt;
      logic        blink_ph;
      ind_t        ind;
      logic        stat_oe;
      logic        run;
      logic        reg_en;
      logic        diode_en;
   } core_t;
endpackage : charge_status_pkg
`default_nettype wire

/* File: charge_status_host.sv */
// host model: pull-up on the status pin and a windowed low-duty meter
`timescale 1ns/10ps
`default_nettype none
module charge_status_host
   import charge_status_pkg::*;
#(
   parameter int WIN = DUTY_STEPS * STEP_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        charge_status_out,
   input  wire logic        charge_status_oe,
   output logic             pin_level,
   output logic             rd_valid,
   output logic [31:0]      rd_low
);
   // ==========================================================
   // pin and meter
   logic [31:0] win_cnt = '0;
   logic [31:0] low_cnt = '0;

   // released pin floats up to the pull-up, never holds a stale value
   assign pin_level = charge_status_oe ? charge_status_out : 1'b1;

   // one reading per carrier period; window is not aligned to the carrier,
   // which is fine since any full period holds the same low count
   always_ff @(posedge clk_sys) begin
      rd_valid <= 1'b0;
      if (win_cnt == WIN - 1) begin
         rd_low   <= low_cnt + {31'h0, ~pin_level};
         rd_valid <= (low_cnt + {31'h0, ~pin_level}) != WIN / 2;
         win_cnt  <= '0;
         low_cnt  <= '0;
      end else begin
         win_cnt <= win_cnt + 1;
         low_cnt <= low_cnt + {31'h0, ~pin_level};
      end
   end
endmodule : charge_status_host
`default_nettype wire

/* File: charge_status_encoder_tb.sv */
// testbench: charger status encoder against the host pin model
`timescale 1ns/10ps
`default_nettype none
module charge_status_encoder_tb
   import charge_status_pkg::*;
;
   // ==========================================================
   // shortened timing: blink halves span whole carrier periods
   localparam int HT    = 3 * DUTY_STEPS * STEP_CYC;
   localparam int HB    = 2 * DUTY_STEPS * STEP_CYC;
   localparam int MSL   = 10;
   localparam int TRK   = 5;
   localparam int SAFE  = 8;
   localparam int LIMIT = 80000;
   logic        clk_sys = 1'b0;
   logic        nrst    = 1'b0;
   sense_t      sn      = '0;
   logic        out, oe, run, reg_en, diode_en, pin, rd_valid;
   logic [31:0] rd_low;
   int          fail_count = 0;
   int          n_checks   = 0;
   int          cycles     = 0;
   int          seed       = 32'hd921;

   always #4 clk_sys = ~clk_sys;

   charge_status_encoder #(.HALF_TEMP(HT), .HALF_BAD(HB), .MS_LEN(MSL), .TRKL_LEN(TRK),
      .SAFE_LEN(SAFE)) dut (.clk_sys(clk_sys), .nrst(nrst), .sense(sn),
      .charge_status_out(out), .charge_status_oe(oe), .charger_run(run),
      .regulator_en(reg_en), .ideal_diode_en(diode_en));

   charge_status_host host (.clk_sys(clk_sys), .charge_status_out(out),
      .charge_status_oe(oe), .pin_level(pin), .rd_valid(rd_valid), .rd_low(rd_low));

   // ==========================================================
   // helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wait_cyc

   // low counts of one carrier period for a given step count
   function automatic logic [31:0] low_of(input logic [4:0] steps);
      return 32'(steps) * 32'(STEP_CYC);
   endfunction : low_of

   // counts cycles where the pin enable is not the expected level
   task automatic steady_oe(input logic exp, input int n, output logic [31:0] bad);
      bad = '0;
      repeat (n) begin
         @(negedge clk_sys);
         if (oe !== exp) bad++;
      end
   endtask : steady_oe

   // both duty values of a blink must appear while the fault lasts
   task automatic duty(input logic [4:0] lo, input int n, output logic [1:0] seen);
      seen = 2'b00;
      repeat (n) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1 && rd_low === low_of(lo)) seen[1] = 1'b1;
         if (rd_valid === 1'b1 && rd_low === low_of(FULL_STEPS - lo)) seen[0] = 1'b1;
      end
   endtask : duty

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run

   // hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         complete_run();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] bad;
      logic [1:0]  seen;
      wait_cyc(12);
      check("diode in reset", diode_en, 1'b1);
      check("oe in reset", oe, 1'b0);
      nrst = 1'b1;
      sn.uvlo_ok = 1'b1;
      wait_cyc(6);
      check("run charging", run, 1'b1);
      check("regulator on", reg_en, 1'b1);
      check("pin low charging", pin, 1'b0);
      // recharge is ignored while charging, so random levels must not disturb
      bad = '0;
      repeat (16 + ($random(seed) & 32'h3F)) begin
         sn.recharge = 1'($random(seed));
         @(negedge clk_sys);
         if (oe !== 1'b1) bad++;
      end
      sn.recharge = 1'b0;
      check("oe steady charging", bad, 0);
      $display("test charging done");
      sn.in_limit = 1'b1;
      sn.eoc = 1'b1;
      steady_oe(1'b1, 30, bad);
      check("eoc in limit", bad, 0);
      sn.in_limit = 1'b0;
      wait_cyc(6);
      steady_oe(1'b0, 20, bad);
      check("oe released done", bad, 0);
      check("pin released", pin, 1'b1);
      sn.eoc = 1'b0;
      sn.charger_disable_input = 1'b1;
      wait_cyc(6);
      check("run disabled", run, 1'b0);
      sn.charger_disable_input = 1'b0;
      wait_cyc(6);
      steady_oe(1'b1, 20, bad);
      check("restart after disable", bad, 0);
      $display("test completion done");
      sn.temp_hot = 1'b1;
      wait_cyc(6);
      check("run paused hot", run, 1'b0);
      duty(TEMP_LO_STEPS, 3 * HT, seen);
      check("temp duty pair", seen, 2'b11);
      sn.thermistor_gnd = 1'b1;
      wait_cyc(6);
      check("run grounded ntc", run, 1'b1);
      steady_oe(1'b1, 20, bad);
      check("oe grounded ntc", bad, 0);
      sn.temp_hot = 1'b0;
      sn.thermistor_gnd = 1'b0;
      $display("test temperature done");
      sn.float_cv = 1'b1;
      sn.temp_cold = 1'b1;
      wait_cyc(4 * SAFE * MSL);
      sn.temp_cold = 1'b0;
      wait_cyc(6);
      steady_oe(1'b1, 20, bad);
      check("safety frozen", bad, 0);
      wait_cyc(SAFE * MSL + 20);
      steady_oe(1'b0, 10, bad);
      check("safety expired", bad, 0);
      sn.float_cv = 1'b0;
      sn.recharge = 1'b1;
      wait_cyc(6);
      sn.recharge = 1'b0;
      sn.bat_low = 1'b1;
      wait_cyc(TRK * MSL + 20);
      duty(BAD_LO_STEPS, 3 * HB, seen);
      check("bad duty pair", seen, 2'b11);
      check("run bad battery", run, 1'b0);
      // host unloads and resets the charger with a disable pulse
      sn.bat_low = 1'b0;
      sn.charger_disable_input = 1'b1;
      wait_cyc(6);
      sn.charger_disable_input = 1'b0;
      wait_cyc(6);
      steady_oe(1'b1, 20, bad);
      check("retry after bad", bad, 0);
      $display("test bad battery done");
      for (int i = 0; i < 3; i++) begin
         sn.susp_lo = (i == 0);
         sn.susp_hi = (i == 1);
         sn.charger_disable_input = (i == 1);
         sn.uvlo_ok = (i != 2);
         wait_cyc(6);
         check("regulator off", reg_en, 1'b0);
         check("diode on", diode_en, 1'b1);
         sn = '0;
         sn.uvlo_ok = 1'b1;
         wait_cyc(6);
         check("regulator back", reg_en, 1'b1);
      end
      $display("test regulator done");
      complete_run();
   end
endmodule : charge_status_encoder_tb
`default_nettype wire
